// *** design/dbt_map.svh ***
/*
 register indices, reset values and fixed constants of the dual byte timer.
 assumes byte address = 4 * index on a 32-bit register bus.
*/
`ifndef DBT_MAP_SVH
`define DBT_MAP_SVH

`define DBT_ADDR_W 18
`define DBT_IDX_CTL 16'hfe18
`define DBT_IDX_PRE 16'hfe19
`define DBT_IDX_LCNT 16'hfe1a
`define DBT_IDX_HCNT 16'hfe1b
`define DBT_IDX_LMAT 16'hfe1c
`define DBT_IDX_HMAT 16'hfe1d
`define DBT_IDX_STAT 16'hfe20
`define DBT_IDX_MASK 16'hfe21
`define DBT_IDX_CFG 16'hfe22

`define DBT_CTL_RST 8'h00
`define DBT_PRE_RST 8'h00
`define DBT_MATCH_RST 8'h00
`define DBT_CNT_RST 8'h00
`define DBT_IRQ_RST 2'h0
`define DBT_ALL_ONES 8'hff
`define DBT_RESP_OKAY 2'h0
`define DBT_RESP_SLVERR 2'h2

`endif

// *** design/dbt_pkg.sv ***
/*
 types shared by the dual byte timer files.
 assumes nothing beyond the map header.
*/
package dbt_pkg;
   typedef enum logic [1:0] {
      DBT_MODE_SPLIT = 2'b00,
      DBT_MODE_PWM = 2'b01,
      DBT_MODE_CASC = 2'b10,
      DBT_MODE_CPWM = 2'b11
   } dbt_mode_t;

   typedef struct packed {
      logic high_half_run;
      logic low_half_run;
      logic cascade_select;
      logic pwm_select;
      logic high_period_flag;
      logic high_irq_enable;
      logic low_period_flag;
      logic low_irq_enable;
   } dbt_ctl_t;

   typedef struct packed {
      logic high_prescale_enable;
      logic [2:0] high_prescale_code;
      logic low_prescale_enable;
      logic [2:0] low_prescale_code;
   } dbt_pre_t;

   typedef struct packed {
      logic valid;
      logic [15:0] idx;
      logic [7:0] data;
   } dbt_wreq_t;
endpackage

// *** design/dbt_prescaler.sv ***
/*
 programmable prescaler: passes every n-th input tick.
 assumes tick_in is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dbt_prescaler #(parameter int W = 8) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic tick_in,
   input wire logic enable,
   input wire logic [2:0] code,
   output logic tick_out
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] lim;

   // divide by one when disabled, else by two to the power code+1
   assign lim = enable ? W'({W{1'b1}} >> (3'd7 - code)) : '0; // [RULE14]
   // a limit lowered mid-run takes effect at the next tick instead of after a full wrap
   assign tick_out = tick_in & (cnt_r >= lim);

   // cleared while stopped so a restart begins a full division
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (!run) begin
         cnt_r <= '0;
      end else if (tick_in) begin
         cnt_r <= tick_out ? '0 : cnt_r + 1'b1; // [RULE14]
      end
   end
endmodule

`default_nettype wire

// *** design/dbt_axil_slave.sv ***
/*
 axi4-lite slave front end of the dual byte timer.
 assumes one write and one read under way at most; decode done by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbt_map.svh"

module dbt_axil_slave import dbt_pkg::*; (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [`DBT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`DBT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output dbt_wreq_t wreq,
   input wire logic wr_err,
   output logic [15:0] rd_idx,
   input wire logic [7:0] rd_data,
   input wire logic rd_err
);
   logic aw_got_r;
   logic w_got_r;
   logic w_lane_r;
   logic [15:0] aw_idx_r;
   logic [7:0] w_data_r;
   logic fire;

   assign s_axi_awready = !aw_got_r;
   assign s_axi_wready = !w_got_r;
   assign s_axi_arready = !s_axi_rvalid;
   assign fire = aw_got_r & w_got_r & !s_axi_bvalid;
   assign wreq = '{valid: fire & w_lane_r, idx: aw_idx_r, data: w_data_r};
   assign rd_idx = s_axi_araddr[`DBT_ADDR_W-1:2];

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_got_r <= 1'b0;
         aw_idx_r <= 16'h0000;
      end else if (s_axi_awvalid && !aw_got_r) begin
         aw_got_r <= 1'b1;
         aw_idx_r <= s_axi_awaddr[`DBT_ADDR_W-1:2];
      end else if (fire) begin
         aw_got_r <= 1'b0;
      end
   end

   // only lane 0 carries register bits, so only its strobe matters
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         w_got_r <= 1'b0;
         w_lane_r <= 1'b0;
         w_data_r <= 8'h00;
      end else if (s_axi_wvalid && !w_got_r) begin
         w_got_r <= 1'b1;
         w_lane_r <= s_axi_wstrb[0];
         w_data_r <= s_axi_wdata[7:0];
      end else if (fire) begin
         w_got_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DBT_RESP_OKAY;
      end else if (fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_err ? `DBT_RESP_SLVERR : `DBT_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DBT_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_data};
         s_axi_rresp <= rd_err ? `DBT_RESP_SLVERR : `DBT_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// *** design/dbt_top.sv ***
/*
 dual byte timer/pwm: registers, two 8-bit halves, pins, interrupt, checks.
 assumes one clock, an axi4-lite master on it, and an asynchronous event pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbt_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE1 - mode 0 low: 2tcyc or events, match period
// RULE2 - mode 0 high: 2tcyc only, match period
// RULE3 - mode 0 pins toggle once per period
// RULE4 - mode 1: two 8-bit pwms on tcyc
// RULE5 - mode 2: high counts low-half periods
// RULE6 - mode 2: low half still interrupts
// RULE7 - mode 2: pins toggle per low/full period
// RULE8 - mode 3: 16-bit timer, low byte pwm
// RULE9 - mode 3: high pin toggles per period
// RULE10 - period end requests enabled interrupt
// RULE11 - stopped half drives pin high
// RULE12 - running with match all ones: pin low
// RULE13 - cascade and pwm bits pick mode
// RULE14 - prescale divides 1 or 2..256
// RULE15 - match buffer follows, reloads at zero
// RULE16 - pwm clears on overflow, sets on match
// RULE17 - period flag sticks until written zero
module dbt_top import dbt_pkg::*; (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [`DBT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`DBT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_event,
   output logic low_output_pin,
   output logic high_output_pin,
   output logic irq
);
   dbt_wreq_t wreq;
   dbt_ctl_t ctl_r;
   dbt_pre_t pre_r;
   dbt_mode_t mode;
   logic [15:0] rd_idx;
   logic [7:0] rd_data;
   logic wr_err;
   logic rd_err;
   logic [7:0] low_match_r;
   logic [7:0] high_match_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic evt_mode_r;
   logic half_r;
   logic evt_s1_r;
   logic evt_s2_r;
   logic evt_d_r;
   logic evt_edge;
   logic [1:0] run;
   logic [1:0] pwm;
   logic [1:0] src;
   logic [1:0] tick;
   logic [1:0] ovf;
   logic [1:0] hit;
   logic [1:0] per;
   logic [1:0] ie;
   logic [1:0] out_r;
   logic [1:0] pin_r;
   logic [1:0][7:0] mdata;
   logic [1:0][7:0] cnt_r;
   logic [1:0][7:0] buf_r;

   ////////////////////////////////////////////////////////////////////////////
   // register bus

   dbt_axil_slave u_bus (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wreq(wreq),
      .wr_err(wr_err),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   function automatic logic mapped(input logic [15:0] i);
      case (i)
         `DBT_IDX_CTL, `DBT_IDX_PRE, `DBT_IDX_LCNT, `DBT_IDX_HCNT,
         `DBT_IDX_LMAT, `DBT_IDX_HMAT, `DBT_IDX_STAT, `DBT_IDX_MASK,
         `DBT_IDX_CFG: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   assign wr_err = !mapped(wreq.idx);
   assign rd_err = !mapped(rd_idx);

   always_comb begin
      case (rd_idx)
         `DBT_IDX_CTL: rd_data = ctl_r;
         `DBT_IDX_PRE: rd_data = pre_r;
         `DBT_IDX_LCNT: rd_data = cnt_r[0];
         `DBT_IDX_HCNT: rd_data = cnt_r[1];
         `DBT_IDX_LMAT: rd_data = low_match_r;
         `DBT_IDX_HMAT: rd_data = high_match_r;
         `DBT_IDX_STAT: rd_data = {6'h00, irq_stat_r};
         `DBT_IDX_MASK: rd_data = {6'h00, irq_mask_r};
         `DBT_IDX_CFG: rd_data = {7'h00, evt_mode_r};
         default: rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers

   // period flags: a write stores the byte, a period end in the same cycle wins
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctl_r <= dbt_ctl_t'(`DBT_CTL_RST);
      end else begin
         if (wreq.valid && wreq.idx == `DBT_IDX_CTL) begin
            ctl_r <= dbt_ctl_t'(wreq.data);
         end
         if (per[0]) begin
            ctl_r.low_period_flag <= 1'b1; // [RULE17]
         end
         if (per[1]) begin
            ctl_r.high_period_flag <= 1'b1; // [RULE17]
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pre_r <= dbt_pre_t'(`DBT_PRE_RST);
         low_match_r <= `DBT_MATCH_RST;
         high_match_r <= `DBT_MATCH_RST;
         irq_mask_r <= `DBT_IRQ_RST;
         evt_mode_r <= 1'b0;
      end else if (wreq.valid) begin
         case (wreq.idx)
            `DBT_IDX_PRE: pre_r <= dbt_pre_t'(wreq.data);
            `DBT_IDX_LMAT: low_match_r <= wreq.data;
            `DBT_IDX_HMAT: high_match_r <= wreq.data;
            `DBT_IDX_MASK: irq_mask_r <= wreq.data[1:0];
            `DBT_IDX_CFG: evt_mode_r <= wreq.data[0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear, set wins over clear

   assign ie = {ctl_r.high_irq_enable, ctl_r.low_irq_enable};

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_r <= `DBT_IRQ_RST;
      end else if (wreq.valid && wreq.idx == `DBT_IDX_STAT) begin
         irq_stat_r <= (irq_stat_r & ~wreq.data[1:0]) | (per & ie); // [RULE10]
      end else begin
         irq_stat_r <= irq_stat_r | (per & ie); // [RULE10] [RULE6]
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////////////
   // count sources

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         half_r <= 1'b0;
      end else begin
         half_r <= ~half_r;
      end
   end

   // two flops before anything looks at the pin, then a rising edge detect
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         evt_s1_r <= 1'b0;
         evt_s2_r <= 1'b0;
         evt_d_r <= 1'b0;
      end else begin
         evt_s1_r <= ext_event;
         evt_s2_r <= evt_s1_r;
         evt_d_r <= evt_s2_r;
      end
   end

   assign evt_edge = evt_s2_r & ~evt_d_r;

   assign mode = dbt_mode_t'({ctl_r.cascade_select, ctl_r.pwm_select}); // [RULE13]
   assign run = {ctl_r.high_half_run, ctl_r.low_half_run};
   // the high half is a pwm only in mode 1; in mode 3 it is the upper timer byte
   assign pwm = {mode == DBT_MODE_PWM, ctl_r.pwm_select}; // [RULE13] [RULE8]
   assign mdata = {high_match_r, low_match_r};

   // events only make sense at the half rate; pwm modes ignore the event pin
   always_comb begin
      src[0] = ctl_r.pwm_select ? 1'b1 : (evt_mode_r ? evt_edge : half_r); // [RULE1] [RULE4]
      case (mode)
         DBT_MODE_SPLIT: src[1] = half_r; // [RULE2]
         DBT_MODE_PWM: src[1] = 1'b1; // [RULE4]
         DBT_MODE_CASC: src[1] = hit[0]; // [RULE5]
         DBT_MODE_CPWM: src[1] = ovf[0]; // [RULE8]
         default: src[1] = 1'b0;
      endcase
   end

   dbt_prescaler #(.W(8)) u_low_pre (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .run(run[0]),
      .tick_in(src[0]),
      .enable(pre_r.low_prescale_enable),
      .code(pre_r.low_prescale_code),
      .tick_out(tick[0])
   );

   dbt_prescaler #(.W(8)) u_high_pre (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .run(run[1]),
      .tick_in(src[1]),
      .enable(pre_r.high_prescale_enable),
      .code(pre_r.high_prescale_code),
      .tick_out(tick[1])
   );

   ////////////////////////////////////////////////////////////////////////////
   // counters, match buffers, outputs; index 0 low half, 1 high half

   for (genvar g = 0; g < 2; g++) begin : g_evt
      assign ovf[g] = tick[g] & (cnt_r[g] == `DBT_ALL_ONES);
      assign hit[g] = tick[g] & (cnt_r[g] == buf_r[g]);
      assign per[g] = pwm[g] ? ovf[g] : hit[g]; // [RULE10]
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= {2{`DBT_CNT_RST}};
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!run[i]) begin
               cnt_r[i] <= `DBT_CNT_RST;
            end else if (tick[i]) begin
               cnt_r[i] <= (hit[i] && !pwm[i]) ? `DBT_CNT_RST : cnt_r[i] + 8'h01; // [RULE1] [RULE2] [RULE5]
            end
         end
      end
   end

   // reload only as the count reaches zero so a period is never cut short
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         buf_r <= {2{`DBT_MATCH_RST}};
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!run[i] || (tick[i] && (ovf[i] || (hit[i] && !pwm[i])))) begin
               buf_r[i] <= mdata[i]; // [RULE15]
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         out_r <= 2'b11;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!run[i]) begin
               out_r[i] <= 1'b1;
            end else if (pwm[i]) begin
               if (hit[i]) begin
                  out_r[i] <= 1'b1; // [RULE16] [RULE4] [RULE8]
               end else if (ovf[i]) begin
                  out_r[i] <= 1'b0; // [RULE16]
               end
            end else if (hit[i]) begin
               out_r[i] <= ~out_r[i]; // [RULE3] [RULE7] [RULE9]
            end
         end
      end
   end

   // forced levels use the match register itself, not the buffer
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_r <= 2'b11;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!run[i]) begin
               pin_r[i] <= 1'b1; // [RULE11]
            end else if (mdata[i] == `DBT_ALL_ONES) begin
               pin_r[i] <= 1'b0; // [RULE12]
            end else begin
               pin_r[i] <= out_r[i];
            end
         end
      end
   end

   assign low_output_pin = pin_r[0];
   assign high_output_pin = pin_r[1];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   chk_low_src_events: assert property ( // [RULE1]
      (mode == DBT_MODE_SPLIT && evt_mode_r && tick[0]) |-> evt_edge)
      else $error("low half counted without an event");

   chk_high_half_rate: assert property ( // [RULE2]
      (mode == DBT_MODE_SPLIT && $past(mode == DBT_MODE_SPLIT) && tick[1]) |=> !tick[1])
      else $error("high half ticked faster than half rate");

   chk_split_toggle: assert property ( // [RULE3]
      (mode == DBT_MODE_SPLIT && run[0] && hit[0]) |=> (out_r[0] != $past(out_r[0]) || !run[0]))
      else $error("low output did not toggle at period end");

   chk_pwm_set: assert property ( // [RULE4]
      (mode == DBT_MODE_PWM && run[1] && hit[1] && !ovf[1]) |=> out_r[1] || !run[1])
      else $error("high pwm not set on match");

   chk_casc_step: assert property ( // [RULE5]
      (mode == DBT_MODE_CASC && tick[1]) |-> hit[0])
      else $error("cascaded high half stepped without low period");

   chk_casc_low_irq: assert property ( // [RULE6]
      (mode == DBT_MODE_CASC && per[0] && ie[0]) |=> irq_stat_r[0])
      else $error("low period interrupt lost in cascade");

   chk_high_toggle: assert property ( // [RULE7] [RULE9]
      (ctl_r.cascade_select && run[1] && hit[1]) |=> (out_r[1] != $past(out_r[1]) || !run[1]))
      else $error("high output did not toggle at full period");

   chk_cpwm_step: assert property ( // [RULE8]
      (mode == DBT_MODE_CPWM && tick[1]) |-> ovf[0])
      else $error("high byte stepped without low pwm period");

   chk_irq_request: assert property ( // [RULE10]
      (per[1] && ie[1]) |=> irq_stat_r[1] ##0 (irq || !irq_mask_r[1]))
      else $error("enabled period end raised no request");

   chk_stop_high: assert property ( // [RULE11]
      (!run[0] && !run[1]) |=> (low_output_pin && high_output_pin))
      else $error("stopped half pin not high");

   chk_ones_low: assert property ( // [RULE12]
      (run[0] && low_match_r == `DBT_ALL_ONES) |=> !low_output_pin)
      else $error("all ones match did not force low");

   chk_ones_high: assert property ( // [RULE12]
      (run[1] && high_match_r == `DBT_ALL_ONES) |=> !high_output_pin)
      else $error("all ones high match did not force low");

   chk_pwm_no_reset: assert property ( // [RULE13]
      (mode == DBT_MODE_PWM && run[1] && hit[1] && !ovf[1]) |=> cnt_r[1] == $past(cnt_r[1]) + 8'h01 || !run[1])
      else $error("pwm counter reset at match");

   chk_pre_bypass: assert property ( // [RULE14]
      (ctl_r.pwm_select && run[0] && !pre_r.low_prescale_enable) |-> tick[0])
      else $error("undivided prescaler missed a tick");

   chk_buf_follow: assert property ( // [RULE15]
      !run[0] |=> buf_r[0] == $past(low_match_r))
      else $error("match buffer did not follow while stopped");

   chk_pwm_clear: assert property ( // [RULE16]
      (ctl_r.pwm_select && run[0] && ovf[0] && !hit[0]) |=> (!out_r[0] || !run[0]))
      else $error("pwm output not cleared on overflow");

   chk_flag_sticky: assert property ( // [RULE17]
      (ctl_r.low_period_flag && !(wreq.valid && wreq.idx == `DBT_IDX_CTL)) |=> ctl_r.low_period_flag)
      else $error("period flag dropped without a write");

   cov_casc_period: cover property (mode == DBT_MODE_CASC && per[1]);
   cov_pwm_cycle: cover property (ctl_r.pwm_select && ovf[0] ##[1:600] hit[0]);
   cov_irq_rise: cover property ($rose(irq));
endmodule

`default_nettype wire

// *** tb/dbt_evt_src.sv ***
/*
 external event source for the low half's count input.
 assumes the bench enables it only in event scenarios.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_evt_src (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic en,
   output logic ext_event
);
   logic [1:0] div_r;
   // rising edge every 8 clocks; idles low when off so no stray edge is counted
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div_r <= 2'h0;
         ext_event <= 1'b0;
      end else if (en) begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3) begin
            ext_event <= !ext_event;
         end
      end else begin
         div_r <= 2'h0;
         ext_event <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_dbt_top.sv ***
/*
 self-checking bench of the dual byte timer over axi4-lite.
 assumes the design's one-cycle answers; all waits are cut by the cycle ceiling.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbt_map.svh"
module tb_dbt_top;
   import dbt_pkg::*;
   logic sys_clk = 1'b0, resetn = 1'b0, ev_en = 1'b0, ext_event;
   logic [`DBT_ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, lpin, hpin, irq;
   logic [7:0] rd;
   logic [1:0] rs;
   logic [15:0] n;
   int err_total = 0, checks_done = 0, cyc = 0;
   always #20 sys_clk = !sys_clk;
   dbt_evt_src dbt_evt_src_inst (.sys_clk(sys_clk), .resetn(resetn), .en(ev_en), .ext_event(ext_event));
   dbt_top dbt_top_inst (.sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_event(ext_event),
      .low_output_pin(lpin), .high_output_pin(hpin), .irq(irq));
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // the run length of a hung wait is bounded here
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // ready is sampled on the falling edge, release lands just after the taking edge
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic a, w;
      @(posedge sys_clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(negedge sys_clk);
      while (awvalid || wvalid) begin
         a = awvalid && awready;
         w = wvalid && wready;
         @(posedge sys_clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         @(negedge sys_clk);
      end
      while (!bvalid) @(negedge sys_clk);
      rs = bresp;
      @(posedge sys_clk);
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [15:0] idx);
      @(posedge sys_clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge sys_clk);
      while (!arready) @(negedge sys_clk);
      @(posedge sys_clk);
      arvalid <= 1'b0;
      @(negedge sys_clk);
      while (!rvalid) @(negedge sys_clk);
      rd = rdata[7:0];
      rs = rresp;
      chk("rdata upper", rdata[31:8], 24'h0);
      @(posedge sys_clk);
      rready <= 1'b0;
   endtask
   // length in clocks of the next complete run of level lvl on a pin
   task automatic run_len(input logic hi, input logic lvl);
      n = 16'h0;
      @(negedge sys_clk);
      while ((hi ? hpin : lpin) === lvl) @(negedge sys_clk);
      while ((hi ? hpin : lpin) !== lvl) @(negedge sys_clk);
      while ((hi ? hpin : lpin) === lvl) begin
         n++;
         @(negedge sys_clk);
      end
   endtask
   logic [15:0] idxs [9] = '{16'hfe18, 16'hfe19, 16'hfe1a, 16'hfe1b, 16'hfe1c, 16'hfe1d, 16'hfe20, 16'hfe21, 16'hfe22};
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      chk("pins stopped", {lpin, hpin, irq}, 3'b110);
      foreach (idxs[i]) begin
         rdr(idxs[i]);
         chk("reset value", {rs, rd}, {`DBT_RESP_OKAY, 8'h00});
      end
      rdr(16'hfe1f);
      chk("unmapped read", rs, `DBT_RESP_SLVERR);
      wr(16'hfe1f, 8'h55);
      chk("unmapped write", rs, `DBT_RESP_SLVERR);
      wr(16'hfe1a, 8'h55);
      rdr(16'hfe1a);
      chk("ro counter", rd, 8'h00);
      // mode 0: low 4 counts of 2 clocks, high 2 counts of 4 prescaled of 2 clocks
      wr(16'hfe1c, 8'h03);
      wr(16'hfe1d, 8'h01);
      wr(16'hfe19, 8'h90);
      wr(16'hfe21, 8'h01);
      wr(16'hfe18, 8'hc5);
      run_len(1'b0, 1'b0);
      chk("m0 low toggle", n, 16'd8);
      run_len(1'b1, 1'b1);
      chk("m0 high toggle", n, 16'd16);
      chk("irq unmasked", irq, 1'b1);
      rdr(16'hfe20);
      chk("status both", rd, 8'h03);
      wr(16'hfe21, 8'h00);
      chk("irq masked", irq, 1'b0);
      rdr(16'hfe18);
      chk("both flags sticky", rd, 8'hcf);
      wr(16'hfe1d, 8'hff);
      repeat (3) @(negedge sys_clk);
      chk("match ff low", hpin, 1'b0);
      wr(16'hfe18, 8'h00);
      wr(16'hfe20, 8'h01);
      repeat (2) @(negedge sys_clk);
      chk("stopped high", {lpin, hpin}, 2'b11);
      wr(16'hfe21, 8'h01);
      chk("status cleared", irq, 1'b0);
      // mode 1 pwm: low 64 clocks of 256 on both channels
      wr(16'hfe19, 8'h00);
      wr(16'hfe1c, 8'h3f);
      wr(16'hfe1d, 8'h3f);
      wr(16'hfe18, 8'hd0);
      run_len(1'b0, 1'b0);
      chk("m1 low time", n, 16'd64);
      run_len(1'b1, 1'b1);
      chk("m1 high time", n, 16'd192);
      // mode 3: high counts low pwm periods of 256 clocks; stop first so counts and buffers restart
      wr(16'hfe18, 8'h00);
      wr(16'hfe1c, 8'h00);
      wr(16'hfe1d, 8'h00);
      wr(16'hfe18, 8'hf0);
      run_len(1'b0, 1'b0);
      chk("m3 low time", n, 16'd1);
      run_len(1'b1, 1'b0);
      chk("m3 high toggle", n, 16'd256);
      // mode 2 on events every 8 clocks: low period of 2 events feeds the high half
      wr(16'hfe18, 8'h00);
      wr(16'hfe1c, 8'h01);
      wr(16'hfe22, 8'h01);
      ev_en <= 1'b1;
      wr(16'hfe18, 8'he1);
      run_len(1'b0, 1'b1);
      chk("m2 low toggle", n, 16'd16);
      run_len(1'b1, 1'b0);
      chk("m2 high toggle", n, 16'd16);
      chk("m2 low irq", irq, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire
